//--- src/extra_ext_irq_and_nibble_port.sv
// extra external interrupt lines, eight-source arbiter and 4-bit port
//
// How it works
// - extra_irq_control sits at 0C0H; every bit except a level-mode pending flag settable/clearable by bit ops.
// - line 2 requests only with bit 2 set; line 3 only with bit 6.
// - each extra line has its own high-priority bit in extra_irq_control.
// - trigger bit one means falling edge, zero means low level; line 2 bit 0.
// - edge mode: flag set on edge, cleared when the core vectors to it.
// - vectors 03H,0BH,13H,1BH,23H,2BH,33H,3BH for sources 0 to 7.
// - same level ties polled from external 0 down to extra line 3.
// - first six enabled by core enable bits 0-5; extra lines by own bits.
// - extra lines detect, flag and service like external 0 and 1.
// - nibble port at 0D8H, low four bits on pins, quasi-bidirectional.
// - port pins 3 and 2 double as the extra interrupt inputs.
// - byte write drives pins, read returns pins, bit ops change bits.
`timescale 1ns/1ns

module extra_ext_irq_and_nibble_port
    import xirq_pkg::*;
#(
    parameter int PORT_WIDTH = 4
) (
    input  wire logic                  sys_clk_in,
    input  wire logic                  rst_in,
    input  wire logic [7:0]            sfr_addr_in,
    input  wire logic                  sfr_wr_in,
    input  wire logic [7:0]            sfr_wdata_in,
    input  wire logic                  sfr_rd_in,
    input  wire logic                  bit_wr_in,
    input  wire logic [7:0]            bit_addr_in,
    input  wire logic                  bit_val_in,
    input  wire logic [5:0]            std_irq_req_in,
    input  wire logic [7:0]            core_irq_enable_in,
    input  wire logic [5:0]            std_priority_in,
    input  wire logic                  irq_ack_in,
    input  wire logic                  irq_return_in,
    input  wire logic [PORT_WIDTH-1:0] port_pin_in,
    output logic [7:0]                 sfr_rdata_out,
    output logic                       sfr_rvalid_out,
    output logic                       irq_req_out,
    output logic [2:0]                 irq_source_out,
    output logic [7:0]                 irq_vector_out,
    output logic                       irq_high_level_out,
    output logic [PORT_WIDTH-1:0]      port_out,
    output logic [PORT_WIDTH-1:0]      port_oe_out,
    output logic [7:0]                 extra_irq_control_out
);

    // ------------------------------------------------------------------
    // state
    // ------------------------------------------------------------------
    logic [7:0]            extra_irq_control_reg;
    logic [7:0]            extra_irq_control_next;
    logic [7:0]            nibble_port_reg;
    logic [7:0]            nibble_port_next;
    logic [PORT_WIDTH-1:0] pin_meta_reg;
    logic [PORT_WIDTH-1:0] pin_sync_reg;
    logic [1:0]            line_prev_reg;
    logic                  active_high_reg;
    logic                  active_low_reg;
    logic [7:0]            sfr_rdata_reg;
    logic                  sfr_rvalid_reg;
    logic                  irq_req_reg;
    logic [2:0]            irq_source_reg;
    logic [7:0]            irq_vector_reg;
    logic                  irq_high_level_reg;
    logic [PORT_WIDTH-1:0] port_oe_reg;

    // ------------------------------------------------------------------
    // register decode
    // ------------------------------------------------------------------
    wire extra_irq_control_byte_wr = sfr_wr_in && (sfr_addr_in == EXTRA_IRQ_CONTROL_ADDR);
    wire port_byte_wr  = sfr_wr_in && (sfr_addr_in == NIBBLE_PORT_ADDR);
    wire extra_irq_control_bit_wr  = bit_wr_in && (bit_addr_in[7:3] == EXTRA_IRQ_CONTROL_BANK);
    wire port_bit_wr   = bit_wr_in && (bit_addr_in[7:3] == NIBBLE_PORT_BANK);
    wire [2:0] bit_idx = bit_addr_in[2:0];

    // ------------------------------------------------------------------
    // extra interrupt inputs from the port pins
    // ------------------------------------------------------------------
    // a pin whose latch is zero is an output we pull low; it must not
    // trip its own interrupt, so it reads as idle high here
    wire line_a = pin_sync_reg[LINE_A_PIN] | ~nibble_port_reg[LINE_A_PIN];
    wire line_b = pin_sync_reg[LINE_B_PIN] | ~nibble_port_reg[LINE_B_PIN];
    wire [1:0] line_now = {line_b, line_a};
    wire [1:0] fall_seen = line_prev_reg & ~line_now;

    wire [1:0] trig_edge = {extra_irq_control_reg[LINE3_TRIGGER_SELECT_BIT],
                            extra_irq_control_reg[LINE2_TRIGGER_SELECT_BIT]};
    wire [1:0] pend_flag = {extra_irq_control_reg[LINE3_PENDING_FLAG_BIT],
                            extra_irq_control_reg[LINE2_PENDING_FLAG_BIT]};
    wire [1:0] line_en   = {extra_irq_control_reg[LINE3_ENABLE_BIT],
                            extra_irq_control_reg[LINE2_ENABLE_BIT]};
    wire [1:0] line_pri  = {extra_irq_control_reg[LINE3_HIGH_PRIORITY_BIT],
                            extra_irq_control_reg[LINE2_HIGH_PRIORITY_BIT]};

    // ------------------------------------------------------------------
    // acknowledge of the currently offered source
    // ------------------------------------------------------------------
    wire ack_line_a = irq_ack_in && irq_req_reg && (irq_source_reg == SRC_LINE_A);
    wire ack_line_b = irq_ack_in && irq_req_reg && (irq_source_reg == SRC_LINE_B);
    wire [1:0] ack_line = {ack_line_b, ack_line_a};

    // ------------------------------------------------------------------
    // next value of extra_irq_control
    // ------------------------------------------------------------------
    logic [7:0] extra_irq_control_sw;
    always_comb begin
        extra_irq_control_sw = extra_irq_control_reg;
        if (extra_irq_control_byte_wr) begin
            extra_irq_control_sw = sfr_wdata_in;
        end else if (extra_irq_control_bit_wr) begin
            extra_irq_control_sw[bit_idx] = bit_val_in;
        end
    end

    logic [1:0] flag_next;
    always_comb begin
        flag_next = 2'b00;
        for (int i = 0; i < 2; i++) begin
            if (trig_edge[i]) begin
                // an edge in the same cycle as a clear still lands
                if (fall_seen[i]) begin
                    flag_next[i] = 1'b1;
                end else if (ack_line[i]) begin
                    flag_next[i] = 1'b0;
                end else begin
                    flag_next[i] = extra_irq_control_sw[i == 0 ? LINE2_PENDING_FLAG_BIT
                                                   : LINE3_PENDING_FLAG_BIT];
                end
            end else begin
                // level mode: flag just mirrors the pin, like external 0/1
                flag_next[i] = ~line_now[i];
            end
        end
    end

    always_comb begin
        extra_irq_control_next = extra_irq_control_sw;
        extra_irq_control_next[LINE2_PENDING_FLAG_BIT] = flag_next[0];
        extra_irq_control_next[LINE3_PENDING_FLAG_BIT] = flag_next[1];
    end

    // ------------------------------------------------------------------
    // nibble port latch
    // ------------------------------------------------------------------
    always_comb begin
        nibble_port_next = nibble_port_reg;
        if (port_byte_wr) begin
            nibble_port_next = sfr_wdata_in;
        end else if (port_bit_wr) begin
            nibble_port_next[bit_idx] = bit_val_in;
        end
    end

    // ------------------------------------------------------------------
    // eight-source arbitration
    // ------------------------------------------------------------------
    wire global_en = core_irq_enable_in[CORE_GLOBAL_ENABLE_BIT];
    wire [7:0] src_req = {pend_flag, std_irq_req_in};
    wire [7:0] src_en  = {line_en, core_irq_enable_in[5:0]};
    wire [7:0] src_pri = {line_pri, std_priority_in};
    wire [7:0] live    = src_req & src_en & {8{global_en}};
    wire [7:0] live_hi = live & src_pri;
    wire [7:0] live_lo = live & ~src_pri;

    logic       hi_any;
    logic [2:0] hi_src;
    logic       lo_any;
    logic [2:0] lo_src;
    always_comb begin
        hi_any = 1'b0;
        hi_src = 3'h0;
        lo_any = 1'b0;
        lo_src = 3'h0;
        // walk from the last polled down so the first polled wins
        for (int i = NUM_SOURCES - 1; i >= 0; i--) begin
            if (live_hi[i]) begin
                hi_any = 1'b1;
                hi_src = 3'(i);
            end
            if (live_lo[i]) begin
                lo_any = 1'b1;
                lo_src = 3'(i);
            end
        end
    end

    // high beats low; high may preempt a running low routine
    wire offer_hi = hi_any && !active_high_reg;
    wire offer_lo = lo_any && !active_high_reg && !active_low_reg;
    wire offer    = offer_hi || offer_lo;
    wire [2:0] offer_src = offer_hi ? hi_src : lo_src;
    // the ack in flight must not be re-offered before its flag drops
    wire hold_off = irq_ack_in && irq_req_reg;

    // ------------------------------------------------------------------
    // read data
    // ------------------------------------------------------------------
    // byte read of the port returns the pins, not the latch
    wire [7:0] port_read = {{(8 - PORT_WIDTH){1'b0}}, pin_sync_reg};
    wire [7:0] read_mux  =
        (sfr_addr_in == EXTRA_IRQ_CONTROL_ADDR) ? extra_irq_control_reg :
        (sfr_addr_in == NIBBLE_PORT_ADDR)       ? port_read : 8'h00;

    // ------------------------------------------------------------------
    // registers
    // ------------------------------------------------------------------
    always_ff @(posedge sys_clk_in) begin
        if (rst_in) begin
            pin_meta_reg <= '1;
            pin_sync_reg <= '1;
        end else begin
            pin_meta_reg <= port_pin_in;
            pin_sync_reg <= pin_meta_reg;
        end
    end

    always_ff @(posedge sys_clk_in) begin
        if (rst_in) begin
            extra_irq_control_reg <= EXTRA_IRQ_CONTROL_RESET;
            nibble_port_reg       <= NIBBLE_PORT_RESET;
            line_prev_reg         <= 2'b11;
        end else begin
            extra_irq_control_reg <= extra_irq_control_next;
            nibble_port_reg       <= nibble_port_next;
            line_prev_reg         <= line_now;
        end
    end

    always_ff @(posedge sys_clk_in) begin
        if (rst_in) begin
            active_high_reg <= 1'b0;
            active_low_reg  <= 1'b0;
        end else if (irq_ack_in && irq_req_reg) begin
            if (irq_high_level_reg) begin
                active_high_reg <= 1'b1;
            end else begin
                active_low_reg <= 1'b1;
            end
        end else if (irq_return_in) begin
            // return ends the innermost routine, the high one if nested
            if (active_high_reg) begin
                active_high_reg <= 1'b0;
            end else begin
                active_low_reg <= 1'b0;
            end
        end
    end

    always_ff @(posedge sys_clk_in) begin
        if (rst_in) begin
            irq_req_reg        <= 1'b0;
            irq_source_reg     <= 3'h0;
            irq_vector_reg     <= 8'h00;
            irq_high_level_reg <= 1'b0;
        end else begin
            irq_req_reg        <= offer && !hold_off;
            irq_source_reg     <= offer_src;
            irq_vector_reg     <= VECTOR_TABLE[offer_src];
            irq_high_level_reg <= offer_hi;
        end
    end

    always_ff @(posedge sys_clk_in) begin
        if (rst_in) begin
            sfr_rdata_reg  <= 8'h00;
            sfr_rvalid_reg <= 1'b0;
            port_oe_reg    <= '0;
        end else begin
            sfr_rdata_reg  <= sfr_rd_in ? read_mux : 8'h00;
            sfr_rvalid_reg <= sfr_rd_in;
            // quasi-bidirectional: only a zero is driven, a one floats high
            port_oe_reg    <= ~nibble_port_next[PORT_WIDTH-1:0];
        end
    end

    // ------------------------------------------------------------------
    // outputs
    // ------------------------------------------------------------------
    assign sfr_rdata_out         = sfr_rdata_reg;
    assign sfr_rvalid_out        = sfr_rvalid_reg;
    assign irq_req_out           = irq_req_reg;
    assign irq_source_out        = irq_source_reg;
    assign irq_vector_out        = irq_vector_reg;
    assign irq_high_level_out    = irq_high_level_reg;
    assign port_out              = nibble_port_reg[PORT_WIDTH-1:0];
    assign port_oe_out           = port_oe_reg;
    assign extra_irq_control_out = extra_irq_control_reg;

endmodule

//--- src/xirq_pkg.sv
// constants for the extra interrupt lines and the nibble port
package xirq_pkg;

    // ------------------------------------------------------------------
    // special-function register addresses
    // ------------------------------------------------------------------
    localparam logic [7:0] EXTRA_IRQ_CONTROL_ADDR = 8'hC0;
    localparam logic [7:0] NIBBLE_PORT_ADDR       = 8'hD8;
    // bit-addressable registers: bit address = byte address + bit index
    localparam logic [4:0] EXTRA_IRQ_CONTROL_BANK = 5'h18;
    localparam logic [4:0] NIBBLE_PORT_BANK       = 5'h1B;

    // ------------------------------------------------------------------
    // field positions in extra_irq_control, plus the global enable bit in core_irq_enable_in
    // ------------------------------------------------------------------
    localparam int LINE2_TRIGGER_SELECT_BIT = 0;
    localparam int LINE2_PENDING_FLAG_BIT   = 1;
    localparam int LINE2_ENABLE_BIT         = 2;
    localparam int LINE2_HIGH_PRIORITY_BIT  = 3;
    localparam int LINE3_TRIGGER_SELECT_BIT = 4;
    localparam int LINE3_PENDING_FLAG_BIT   = 5;
    localparam int LINE3_ENABLE_BIT         = 6;
    localparam int LINE3_HIGH_PRIORITY_BIT  = 7;
    localparam int CORE_GLOBAL_ENABLE_BIT   = 7;

    // ------------------------------------------------------------------
    // port pin mapping of the extra lines
    // ------------------------------------------------------------------
    localparam int LINE_A_PIN = 3;
    localparam int LINE_B_PIN = 2;

    // ------------------------------------------------------------------
    // values after reset
    // ------------------------------------------------------------------
    localparam logic [7:0] EXTRA_IRQ_CONTROL_RESET = 8'h00;
    localparam logic [7:0] NIBBLE_PORT_RESET       = 8'hFF;

    // ------------------------------------------------------------------
    // sources in polling order, 0 polled first
    // ------------------------------------------------------------------
    localparam int          NUM_SOURCES = 8;
    localparam logic [2:0]  SRC_LINE_A  = 3'h6;
    localparam logic [2:0]  SRC_LINE_B  = 3'h7;
    localparam logic [7:0]  VECTOR_TABLE [NUM_SOURCES] = '{
        8'h03, 8'h0B, 8'h13, 8'h1B, 8'h23, 8'h2B, 8'h33, 8'h3B
    };

endpackage

//--- verif/nibble_pin_partner.sv
// far-side pin model: pull-ups plus outside devices pulling pins low
`timescale 1ns/1ns

module nibble_pin_partner (
    input  wire logic [3:0] port_oe_in,
    input  wire logic [3:0] pull_low_in,
    output logic      [3:0] pin_level_out
);
    // released pins rise to the pull-up, never keep the last driven level
    assign pin_level_out = ~(port_oe_in | pull_low_in);
endmodule

//--- verif/tb_extra_ext_irq_and_nibble_port.sv
// self-checking bench for the extra interrupt lines and nibble port
`timescale 1ns/1ns

module tb_extra_ext_irq_and_nibble_port;
    logic       clk = 0, rst = 1, wr = 0, rd = 0, bwr = 0, bval = 0, ack = 0, ret = 0;
    logic [7:0] addr = 0, wdata = 0, baddr = 0, core_en = 0, rdata, vec, ctrl, r, d;
    logic [5:0] std_req = 0, std_pri = 0;
    logic [3:0] pull = 0, pins, pout, poe;
    logic [2:0] src;
    logic       req, hi, rv;
    int         mismatches = 0, total_checks = 0, cycles = 0, seed = 3, b;

    extra_ext_irq_and_nibble_port #(.PORT_WIDTH(4)) uut (
        .sys_clk_in(clk), .rst_in(rst), .sfr_addr_in(addr), .sfr_wr_in(wr),
        .sfr_wdata_in(wdata), .sfr_rd_in(rd), .bit_wr_in(bwr), .bit_addr_in(baddr),
        .bit_val_in(bval), .std_irq_req_in(std_req), .core_irq_enable_in(core_en),
        .std_priority_in(std_pri), .irq_ack_in(ack), .irq_return_in(ret), .port_pin_in(pins),
        .sfr_rdata_out(rdata), .sfr_rvalid_out(rv), .irq_req_out(req), .irq_source_out(src),
        .irq_vector_out(vec), .irq_high_level_out(hi), .port_out(pout), .port_oe_out(poe),
        .extra_irq_control_out(ctrl));
    nibble_pin_partner far_end (.port_oe_in(poe), .pull_low_in(pull), .pin_level_out(pins));

    always #5 clk = ~clk;
    always @(posedge clk) begin
        cycles <= cycles + 1;
        if (cycles == 20000) begin
            mismatches = mismatches + 1;
            report_and_stop();
        end
    end

    // --------------------------------------------------------------
    // helpers
    // --------------------------------------------------------------
    function automatic logic [7:0] port_read_exp(input logic [3:0] latch, input logic [3:0] low);
        return {4'h0, latch & ~low};
    endfunction
    task automatic check(input string what, input logic [7:0] exp, input logic [7:0] got);
        total_checks++;
        if (got !== exp) begin
            mismatches++;
            $display("Error %s expected %h seen %h", what, exp, got);
        end
    endtask
    task automatic wait_cycles(input int n);
        repeat (n) @(posedge clk);
        #1;
    endtask
    task automatic wr_byte(input logic [7:0] a, input logic [7:0] v);
        @(posedge clk);
        addr <= a;
        wdata <= v;
        wr <= 1'b1;
        @(posedge clk);
        wr <= 1'b0;
        #1;
    endtask
    task automatic wr_bit(input logic [7:0] a, input logic v);
        @(posedge clk);
        baddr <= a;
        bval <= v;
        bwr <= 1'b1;
        @(posedge clk);
        bwr <= 1'b0;
        #1;
    endtask
    task automatic rd_byte(input logic [7:0] a, output logic [7:0] v);
        @(posedge clk);
        addr <= a;
        rd <= 1'b1;
        @(posedge clk);
        rd <= 1'b0;
        #1;
        v = rdata;
        check("read valid", 8'h01, {7'h0, rv});
    endtask
    task automatic pulse(input logic is_ack);
        @(posedge clk);
        if (is_ack) ack <= 1'b1;
        else ret <= 1'b1;
        @(posedge clk);
        ack <= 1'b0;
        ret <= 1'b0;
        #1;
    endtask
    // bounded wait for an offer, then source, vector and level
    task automatic wait_req(input logic [2:0] s, input logic h);
        for (int n = 0; n < 20 && req !== 1'b1; n++) wait_cycles(1);
        check("irq source", {5'h0, s}, {5'h0, src});
        check("irq vector", {2'h0, s, 3'h3}, vec);
        check("irq level", {7'h0, h}, {7'h0, hi});
    endtask
    task automatic report_and_stop;
        $display("total_checks %0d mismatches %0d", total_checks, mismatches);
        if (mismatches == 0 && total_checks > 0) begin
            $display("== PASSED ==");
        end else begin
            $display("== FAILED ==");
        end
        $finish;
    endtask

    // --------------------------------------------------------------
    // main sequence
    // --------------------------------------------------------------
    initial begin
        wait_cycles(16);
        rst <= 1'b0;
        check("control reset", 8'h00, ctrl);
        check("port reset", 8'h0F, {4'h0, pout});
        check("drive reset", 8'h00, {4'h0, poe});
        rd_byte(8'h90, r);
        check("unmapped read", 8'h00, r);
        for (int i = 0; i < 8; i++) begin
            wr_bit(8'hC0 + 8'(i), 1'b1);
            check("control bit set", 8'h01, {7'h0, ctrl[i]});
        end
        for (int i = 7; i >= 0; i--) begin
            wr_bit(8'hC0 + 8'(i), 1'b0);
            check("control bit clear", 8'h00, {7'h0, ctrl[i]});
        end
        wr_byte(8'hC0, 8'h44);
        rd_byte(8'hC0, r);
        check("control read", 8'h44, r);
        for (int i = 0; i < 8; i++) begin
            d = 8'($random(seed));
            pull <= 4'($random(seed));
            wr_byte(8'hD8, d);
            check("port write", {4'h0, d[3:0]}, {4'h0, pout});
            check("port drive", {4'h0, ~d[3:0]}, {4'h0, poe});
            wait_cycles(3);
            rd_byte(8'hD8, r);
            check("port read", port_read_exp(d[3:0], pull), r);
            b = $unsigned($random(seed)) % 4;
            wr_bit(8'hD8 + 8'(b), d[7]);
            check("port bit op", {7'h0, d[7]}, {7'h0, pout[b]});
        end
        wr_byte(8'hD8, 8'hFF);
        pull <= 4'h0;
        core_en <= 8'hFF;
        wr_byte(8'hC0, 8'h01);
        pull[3] <= 1'b1;
        wait_cycles(8);
        check("disabled line offer", 8'h00, {7'h0, req});
        check("edge flag", 8'h01, {7'h0, ctrl[1]});
        wr_bit(8'hC2, 1'b1);
        wait_req(3'h6, 1'b0);
        pull[3] <= 1'b0;
        pulse(1'b1);
        check("edge flag after ack", 8'h00, {7'h0, ctrl[1]});
        pulse(1'b0);
        for (int s = 0; s < 6; s++) begin
            @(posedge clk);
            core_en <= 8'h80;
            std_req <= 6'(1 << s);
            wait_cycles(4);
            check("masked source", 8'h00, {7'h0, req});
            core_en <= 8'h80 | 8'(1 << s);
            wait_req(3'(s), 1'b0);
            std_req <= 6'h00;
        end
        @(posedge clk);
        core_en <= 8'hFF;
        std_req <= 6'h3F;
        pull <= 4'hC;
        wr_byte(8'hC0, 8'h44);
        wait_cycles(6);
        for (int k = 0; k < 8; k++) begin
            wait_req(3'(k), 1'b0);
            if (k < 6) std_req[k] <= 1'b0;
            else pull[9 - k] <= 1'b0;
            wait_cycles(6);
        end
        std_req <= 6'h3F;
        wr_bit(8'hC7, 1'b1);
        pull[2] <= 1'b1;
        wait_cycles(4);
        wait_req(3'h7, 1'b1);
        pulse(1'b1);
        wait_cycles(4);
        check("offer while high active", 8'h00, {7'h0, req});
        pull[2] <= 1'b0;
        pulse(1'b0);
        wait_cycles(6);
        wait_req(3'h0, 1'b0);
        pulse(1'b1);
        pull[2] <= 1'b1;
        wait_cycles(4);
        wait_req(3'h7, 1'b1);
        // timer 2 raised to high level: polled ahead of extra line 3 there
        @(posedge clk);
        std_pri <= 6'h20;
        wait_cycles(4);
        wait_req(3'h5, 1'b1);
        report_and_stop();
    end
endmodule

//--- verif/xirq_checker_assertions.sv
// port-level assertions for the extra interrupt lines and nibble port
`timescale 1ns/1ns

module xirq_checker
    import xirq_pkg::*;
#(
    parameter int PORT_WIDTH = 4
) (
    input wire logic                  sys_clk_in,
    input wire logic                  rst_in,
    input wire logic [7:0]            sfr_addr_in,
    input wire logic                  sfr_wr_in,
    input wire logic [7:0]            sfr_wdata_in,
    input wire logic                  sfr_rd_in,
    input wire logic                  irq_ack_in,
    input wire logic [PORT_WIDTH-1:0] port_pin_in,
    input wire logic [7:0]            sfr_rdata_out,
    input wire logic                  sfr_rvalid_out,
    input wire logic                  irq_req_out,
    input wire logic [2:0]            irq_source_out,
    input wire logic [7:0]            irq_vector_out,
    input wire logic                  irq_high_level_out,
    input wire logic [PORT_WIDTH-1:0] port_out,
    input wire logic [PORT_WIDTH-1:0] port_oe_out,
    input wire logic [7:0]            extra_irq_control_out
);
    // --------------------------------------------------------------
    // single clock domain
    // --------------------------------------------------------------
    default clocking cb @(posedge sys_clk_in); endclocking
    default disable iff (rst_in);

    a_read_unmapped: assert property (
        sfr_rd_in && sfr_addr_in != EXTRA_IRQ_CONTROL_ADDR && sfr_addr_in != NIBBLE_PORT_ADDR
        |=> sfr_rvalid_out && sfr_rdata_out == 8'h00) else $error("unmapped read wrong");
    // pending bits excluded: hardware owns them
    a_ctrl_byte_write: assert property (
        sfr_wr_in && sfr_addr_in == EXTRA_IRQ_CONTROL_ADDR
        |=> (extra_irq_control_out & 8'hDD) == ($past(sfr_wdata_in) & 8'hDD))
        else $error("control byte write lost");
    a_port_byte_write: assert property (
        sfr_wr_in && sfr_addr_in == NIBBLE_PORT_ADDR |=> port_out == $past(sfr_wdata_in[3:0]))
        else $error("port byte write lost");
    a_oe_from_latch: assert property (port_oe_out == ~port_out)
        else $error("pin drive does not follow latch");
    a_vector_from_source: assert property (
        irq_req_out |-> irq_vector_out == {2'h0, irq_source_out, 3'h3}) else $error("bad vector");
    a_line_a_enable: assert property (
        irq_req_out && irq_source_out == 3'h6 && $stable(extra_irq_control_out)
        |-> extra_irq_control_out[2]) else $error("line a offered while disabled");
    a_line_a_level: assert property (
        irq_req_out && irq_source_out == 3'h6 && $stable(extra_irq_control_out)
        |-> irq_high_level_out == extra_irq_control_out[3]) else $error("line a level wrong");
    a_ack_drops_offer: assert property (irq_ack_in && irq_req_out |=> !irq_req_out)
        else $error("offer stands after ack");
    a_level_mirror: assert property (
        (!port_pin_in[3] && port_out[3] && !extra_irq_control_out[0]) [*4]
        |-> extra_irq_control_out[1]) else $error("level request not flagged");
    a_edge_sets_flag: assert property (
        $fell(port_pin_in[3]) && $past(port_pin_in[3], 2) && port_out[3] && extra_irq_control_out[0]
        |-> ##[1:4] extra_irq_control_out[1]) else $error("edge not flagged");
    a_poll_line_b_last: assert property (
        irq_req_out && irq_source_out == 3'h7 && !irq_high_level_out && $stable(extra_irq_control_out)
        |-> !(extra_irq_control_out[1] && extra_irq_control_out[2])) else $error("poll order");
endmodule

bind extra_ext_irq_and_nibble_port xirq_checker #(.PORT_WIDTH(PORT_WIDTH)) chk (
    .sys_clk_in(sys_clk_in), .rst_in(rst_in), .sfr_addr_in(sfr_addr_in),
    .sfr_wr_in(sfr_wr_in), .sfr_wdata_in(sfr_wdata_in), .sfr_rd_in(sfr_rd_in),
    .irq_ack_in(irq_ack_in), .port_pin_in(port_pin_in), .sfr_rdata_out(sfr_rdata_out),
    .sfr_rvalid_out(sfr_rvalid_out), .irq_req_out(irq_req_out), .irq_source_out(irq_source_out),
    .irq_vector_out(irq_vector_out), .irq_high_level_out(irq_high_level_out),
    .port_out(port_out), .port_oe_out(port_oe_out), .extra_irq_control_out(extra_irq_control_out));
